// ### logic/tcc_ctrl.sv
// clear, interrupt and transfer termination logic of the tape controller
`timescale 1ns/1ps
`default_nettype none
module tcc_ctrl
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // host bus reset and interrupt
    input wire logic bus_init,
    input wire logic irq_ack,
    output logic irq,
    // transfer engine and drive events; all but the drive error bits are one-cycle pulses
    input wire logic gap_seen,
    input wire logic [7:0] ctl_err_set,
    input wire logic par_err_set,
    input wire logic [4:0] cs3_err_set,
    input wire logic drv_err_set,
    input wire logic [15:0] drv_err_bits,
    input wire logic [7:0] drv_attn_set,
    // drive bus and transfer status
    output logic drive_bus_init,
    output logic xfer_active
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        tcc_xfer_t xs;
        logic transfer_error_flag;
        logic mcpe;
        logic rdy;
        logic ie;
        logic [7:0] cs2_err;
        logic [4:0] cs3_err;
        logic [2:0] unit;
        logic address_increment_inhibit;
        logic parity_test_bit;
        logic [3:0] parity_check_invert;
        logic double_buffer_bit;
        logic [15:0] ba;
        logic [5:0] bae;
        logic [15:0] db;
        logic db_full;
        logic [7:0] go;
        logic [7:0] attention_active_flag;
        logic [7:0] err;
        logic [7:0] slave_status_change;
        logic [7:0] drive_ready_flag;
        logic [7:0][4:0] fn;
        logic [7:0][15:0] er;
        logic rdy_prev;
        logic sc_prev;
        logic irq;
        logic init;
    } tcc_state_t;

    tcc_state_t s_q;
    tcc_state_t s_d;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    endfunction

    logic req;
    logic wr;
    logic sc;
    logic [15:0] cs1_w;
    logic [15:0] cs2_w;
    logic [15:0] cs3_w;
    logic [15:0] as_w;
    logic [15:0] rd16;

    assign req = cyc_i && stb_i;
    // write acts on the edge that samples ack high
    assign wr = req && we_i && s_q.ack;
    assign sc = s_q.transfer_error_flag || (|s_q.attention_active_flag);
    assign cs1_w = merge16(rd_cs1(s_q, sc), dat_i, sel_i);
    assign cs2_w = merge16({s_q.cs2_err, 2'h0, 1'b0, s_q.parity_test_bit, s_q.address_increment_inhibit, s_q.unit}, dat_i, sel_i);
    assign cs3_w = merge16({s_q.cs3_err, 4'h0, s_q.ie, 1'b0, s_q.double_buffer_bit, s_q.parity_check_invert}, dat_i, sel_i);
    assign as_w = merge16(16'h0000, dat_i, sel_i);

    // status one image, ready and special are live
    function automatic logic [15:0] rd_cs1(input tcc_state_t s, input logic scv);
        rd_cs1 = {scv, s.transfer_error_flag, s.mcpe, 5'h00, s.rdy, s.ie, s.fn[s.unit], s.go[s.unit]};
    endfunction

    // read mux for the register map; unmapped reads give zero
    always_comb begin
        rd16 = 16'h0000;
        case (adr_i)
            OFS_CS1: rd16 = rd_cs1(s_q, sc);
            OFS_CS2: rd16 = {s_q.cs2_err, 2'h0, 1'b0, s_q.parity_test_bit, s_q.address_increment_inhibit, s_q.unit};
            OFS_CS3: rd16 = {s_q.cs3_err, 4'h0, s_q.ie, 1'b0, s_q.double_buffer_bit, s_q.parity_check_invert};
            OFS_BA: rd16 = s_q.ba;
            OFS_BAE: rd16 = {10'h000, s_q.bae};
            OFS_DS: begin
                rd16[DS_ATA] = s_q.attention_active_flag[s_q.unit];
                rd16[DS_ERR] = s_q.err[s_q.unit];
                rd16[DS_DRY] = s_q.drive_ready_flag[s_q.unit];
                rd16[DS_SSC] = s_q.slave_status_change[s_q.unit];
                rd16[DS_GO] = s_q.go[s_q.unit];
            end
            OFS_ER: rd16 = s_q.er[s_q.unit];
            OFS_AS: rd16 = {8'h00, s_q.attention_active_flag};
            OFS_DB: rd16 = s_q.db;
            default: rd16 = 16'h0000;
        endcase
    end

    // next-state logic for bus, clears, drives, transfer and interrupt
    always_comb begin
        logic ctl_clear;
        logic err_clear;
        logic dclr;
        logic xgo;
        logic any_err;
        logic irq_set;
        ctl_clear = 1'b0;
        err_clear = 1'b0;
        dclr = 1'b0;
        xgo = 1'b0;
        any_err = 1'b0;
        irq_set = 1'b0;
        s_d = s_q;
        s_d.init = 1'b0;
        // single-wait-state slave: ack one cycle after the request, then drop
        s_d.ack = req && !s_q.ack;
        if (req && !s_q.ack) begin
            s_d.rdata = {16'h0000, rd16};
        end
        // decode register writes
        if (wr) begin
            case (adr_i)
                OFS_CS1: begin
                    s_d.ie = cs1_w[CS1_IE];
                    if (cs1_w[CS1_TRE]) begin
                        err_clear = 1'b1;
                    end
                    // enable and ready written as ones together interrupt while the controller is ready
                    if (cs1_w[CS1_IE] && cs1_w[CS1_RDY] && s_q.rdy) begin
                        irq_set = 1'b1;
                    end
                    if (cs1_w[CS1_GO]) begin
                        if (cs1_w[5:1] == FN_DRIVE_CLEAR) begin
                            dclr = 1'b1;
                        end else if (cs1_w[5:1] >= FN_FIRST_XFER && s_q.rdy) begin
                            xgo = 1'b1;
                        end else if (!s_q.err[s_q.unit]) begin
                            s_d.fn[s_q.unit] = cs1_w[5:1];
                        end
                    end
                end
                OFS_CS2: begin
                    s_d.unit = cs2_w[2:0];
                    s_d.address_increment_inhibit = cs2_w[CS2_BAI];
                    s_d.parity_test_bit = cs2_w[CS2_PAT];
                    ctl_clear = cs2_w[CS2_CLR];
                end
                // enable alias here never interrupts at once
                OFS_CS3: begin
                    s_d.ie = cs3_w[CS3_IE];
                    s_d.double_buffer_bit = cs3_w[CS3_DBL];
                    s_d.parity_check_invert = cs3_w[3:0];
                end
                OFS_BA: s_d.ba = merge16(s_q.ba, dat_i, sel_i);
                OFS_BAE: s_d.bae = sel_i[0] ? dat_i[5:0] : s_q.bae;
                OFS_AS: s_d.attention_active_flag = s_q.attention_active_flag & ~as_w[7:0];
                OFS_DB: begin
                    s_d.db = merge16(s_q.db, dat_i, sel_i);
                    s_d.db_full = 1'b1;
                end
                default: s_d.db_full = s_q.db_full;
            endcase
        end
        // start, clear and bus reset drop controller errors too; error events still win
        err_clear = err_clear || xgo || ctl_clear || bus_init;
        if (err_clear) begin
            s_d.cs2_err = 8'h00;
            s_d.transfer_error_flag = 1'b0;
            s_d.mcpe = 1'b0;
            s_d.cs3_err = 5'h00;
        end
        // data transfer start: clear errors and buffer, drop both readies, or flag CS2_ERR_MXF if the selected drive has an error
        if (xgo) begin
            s_d.db_full = 1'b0;
            if (s_q.err[s_q.unit]) begin
                s_d.cs2_err = CS2_ERR_MXF;
                s_d.transfer_error_flag = 1'b1;
            end else begin
                s_d.fn[s_q.unit] = cs1_w[5:1];
                s_d.go[s_q.unit] = 1'b1;
                s_d.drive_ready_flag[s_q.unit] = 1'b0;
                s_d.rdy = 1'b0;
                s_d.xs = TCC_XFER;
            end
        end
        // controller errors: flag, stop at once, ready waits for the gap
        any_err = (|ctl_err_set) || par_err_set || (|cs3_err_set);
        s_d.cs2_err = s_d.cs2_err | ctl_err_set;
        s_d.mcpe = s_d.mcpe | par_err_set;
        s_d.cs3_err = s_d.cs3_err | cs3_err_set;
        if (any_err) begin
            s_d.transfer_error_flag = 1'b1;
            if (s_q.xs == TCC_XFER) begin
                s_d.xs = TCC_WAIT_GAP;
            end
        end
        // inter-record gap ends the transfer normally or after an error
        if (gap_seen && s_q.xs != TCC_IDLE) begin
            s_d.rdy = 1'b1;
            s_d.drive_ready_flag[s_q.unit] = 1'b1;
            s_d.go[s_q.unit] = 1'b0;
            s_d.xs = TCC_IDLE;
        end
        // drive error on the selected drive
        if (drv_err_set) begin
            s_d.err[s_q.unit] = 1'b1;
            s_d.er[s_q.unit] = s_q.er[s_q.unit] | drv_err_bits |
                ((drv_err_bits == 16'h0000) ? ER_DEFAULT_BIT : 16'h0000);
            s_d.transfer_error_flag = 1'b1;
            s_d.rdy = 1'b1;
            s_d.drive_ready_flag[s_q.unit] = 1'b1;
            s_d.attention_active_flag[s_q.unit] = 1'b1;
            s_d.go[s_q.unit] = 1'b0;
            s_d.xs = TCC_IDLE;
        end
        s_d.attention_active_flag = s_d.attention_active_flag | drv_attn_set;
        // drive clear resets the selected drive and ends any running transfer, never transfer error
        if (dclr) begin
            s_d.go[s_q.unit] = 1'b0;
            s_d.attention_active_flag[s_q.unit] = 1'b0;
            s_d.err[s_q.unit] = 1'b0;
            s_d.er[s_q.unit] = 16'h0000;
            s_d.fn[s_q.unit] = 5'h00;
            s_d.slave_status_change[s_q.unit] = 1'b0;
            s_d.drive_ready_flag[s_q.unit] = 1'b1;
            if (s_q.xs != TCC_IDLE) begin
                s_d.rdy = 1'b1;
                s_d.xs = TCC_IDLE;
            end
        end
        // controller clear or bus reset: abort everything, ready at once
        if (ctl_clear || bus_init) begin
            s_d.db_full = 1'b0;
            s_d.ba = 16'h0000;
            s_d.bae = 6'h00;
            s_d.unit = 3'h0;
            s_d.ie = 1'b0;
            s_d.address_increment_inhibit = 1'b0;
            s_d.parity_test_bit = 1'b0;
            s_d.parity_check_invert = 4'h0;
            s_d.double_buffer_bit = 1'b0;
            s_d.init = 1'b1;
            s_d.go = 8'h00;
            s_d.attention_active_flag = 8'h00;
            s_d.err = 8'h00;
            s_d.slave_status_change = 8'h00;
            s_d.fn = '0;
            s_d.er = '0;
            s_d.drive_ready_flag = RST_DRY;
            s_d.rdy = 1'b1;
            s_d.xs = TCC_IDLE;
        end
        // edges of registered flags feed the interrupt
        s_d.rdy_prev = s_q.rdy;
        s_d.sc_prev = sc;
        if (s_q.rdy && !s_q.rdy_prev && s_q.ie) begin
            irq_set = 1'b1;
        end
        if (sc && !s_q.sc_prev && s_q.rdy && s_q.ie) begin
            irq_set = 1'b1;
        end
        // request held until acknowledged, a new request wins over the ack
        if (irq_ack) begin
            s_d.irq = 1'b0;
        end
        if (irq_set) begin
            s_d.irq = 1'b1;
        end
    end

    // single state register; ready and drive readies come up set
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.rdy <= 1'b1;
            s_q.rdy_prev <= 1'b1;
            s_q.drive_ready_flag <= RST_DRY;
        end else begin
            s_q <= s_d;
        end
    end

    assign dat_o = s_q.rdata;
    assign ack_o = s_q.ack;
    assign irq = s_q.irq;
    assign drive_bus_init = s_q.init;
    assign xfer_active = (s_q.xs == TCC_XFER);
    logic dclr_chk;
    assign dclr_chk = cs1_w[CS1_GO] && cs1_w[5:1] == FN_DRIVE_CLEAR;

    // checks
    clr_errs_a: assert property (@(posedge clk) disable iff (rst)
        wr && adr_i == OFS_CS2 && cs2_w[CS2_CLR] |=> s_q.cs2_err == 8'h00 || $past(|ctl_err_set))
        else $error("clear left controller errors");
    clr_init_a: assert property (@(posedge clk) disable iff (rst)
        (wr && adr_i == OFS_CS2 && cs2_w[CS2_CLR]) || bus_init |=> drive_bus_init && s_q.rdy)
        else $error("clear did not pulse drive init");
    clr_buf_a: assert property (@(posedge clk) disable iff (rst)
        bus_init |=> !s_q.db_full && s_q.ba == 16'h0000 && !s_q.ie)
        else $error("clear left buffer or address");
    tre_keep_a: assert property (@(posedge clk) disable iff (rst)
        wr && adr_i == OFS_CS1 && cs1_w[CS1_TRE] && !bus_init && !dclr_chk
        |=> s_q.err == $past(s_q.err) || $past(drv_err_set))
        else $error("error clear touched drive error");
    rdy_irq_a: assert property (@(posedge clk) disable iff (rst)
        s_q.rdy && !s_q.rdy_prev && s_q.ie |=> irq)
        else $error("no interrupt on ready");
    irq_hold_a: assert property (@(posedge clk) disable iff (rst)
        irq && !irq_ack |=> irq)
        else $error("interrupt dropped before ack");
    err_stop_a: assert property (@(posedge clk) disable iff (rst)
        xfer_active && (|ctl_err_set) && !gap_seen && !drv_err_set && !bus_init && !wr
        |=> !xfer_active && !s_q.rdy && s_q.transfer_error_flag)
        else $error("error did not stop transfer");
    drv_err_a: assert property (@(posedge clk) disable iff (rst)
        drv_err_set && !bus_init && !wr |=> s_q.transfer_error_flag && s_q.rdy && sc && s_q.err[s_q.unit])
        else $error("drive error flags missing");
    sc_def_a: assert property (@(posedge clk) disable iff (rst)
        s_q.transfer_error_flag && adr_i == OFS_CS1 |-> rd16[CS1_SC])
        else $error("special conditions missing");
endmodule
`default_nettype wire

// ### logic/tcc_pkg.sv
// constants and types shared by the tape controller clear and interrupt block
package tcc_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [5:0] OFS_CS1 = 6'h00;
    localparam logic [5:0] OFS_CS2 = 6'h04;
    localparam logic [5:0] OFS_CS3 = 6'h08;
    localparam logic [5:0] OFS_BA = 6'h0c;
    localparam logic [5:0] OFS_BAE = 6'h10;
    localparam logic [5:0] OFS_DS = 6'h14;
    localparam logic [5:0] OFS_ER = 6'h18;
    localparam logic [5:0] OFS_AS = 6'h1c;
    localparam logic [5:0] OFS_DB = 6'h20;
    // control_status_one fields
    localparam int CS1_SC = 15;
    localparam int CS1_TRE = 14;
    localparam int CS1_MCPE = 13;
    localparam int CS1_RDY = 7;
    localparam int CS1_IE = 6;
    localparam int CS1_GO = 0;
    // control_status_two fields
    localparam int CS2_CLR = 5;
    localparam int CS2_BAI = 3;
    localparam int CS2_PAT = 4;
    // control_status_three fields
    localparam int CS3_IE = 6;
    localparam int CS3_DBL = 4;
    // drive status fields
    localparam int DS_ATA = 15;
    localparam int DS_ERR = 14;
    localparam int DS_DRY = 7;
    localparam int DS_SSC = 6;
    localparam int DS_GO = 0;
    // function codes, bits 5:1 of control_status_one, then error and reset constants
    localparam logic [4:0] FN_DRIVE_CLEAR = 5'h04;
    localparam logic [4:0] FN_FIRST_XFER = 5'h14;
    localparam logic [7:0] CS2_ERR_MXF = 8'h02;
    localparam logic [15:0] ER_DEFAULT_BIT = 16'h0001;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_DRY = 8'hff;

    typedef enum logic [1:0] {
        TCC_IDLE,
        TCC_XFER,
        TCC_WAIT_GAP
    } tcc_xfer_t;
endpackage

// ### verification/tb_tcc_ctrl.sv
// self-checking bench for the tape controller clear and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_tcc_ctrl
    import tcc_pkg::*;
;
    logic clk, rst, cyc_i, stb_i, we_i, bus_init, irq_ack, ack_o, irq;
    logic [5:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, mon_e;
    logic drive_bus_init, xfer_active, gap_seen, par_err_set, drv_err_set;
    logic [7:0] ctl_err_set, drv_attn_set;
    logic [4:0] cs3_err_set;
    logic [15:0] drv_err_bits, rnd;
    logic [31:0] lfsr = 32'h26c2;
    logic [31:0] exp_q[$];
    int bad_count = 0;
    int comparisons = 0;
    int init_cnt = 0;
    int k0;

    tcc_ctrl u_dut (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .bus_init(bus_init), .irq_ack(irq_ack), .irq(irq), .gap_seen(gap_seen),
        .ctl_err_set(ctl_err_set), .par_err_set(par_err_set), .cs3_err_set(cs3_err_set),
        .drv_err_set(drv_err_set), .drv_err_bits(drv_err_bits), .drv_attn_set(drv_attn_set),
        .drive_bus_init(drive_bus_init), .xfer_active(xfer_active));
    tcc_far_model u_far (.clk(clk), .gap_seen(gap_seen), .ctl_err_set(ctl_err_set),
        .par_err_set(par_err_set), .cs3_err_set(cs3_err_set), .drv_err_set(drv_err_set),
        .drv_err_bits(drv_err_bits), .drv_attn_set(drv_attn_set),
        .xfer_active(xfer_active), .drive_bus_init(drive_bus_init));

    // free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic close_out();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    // one classic cycle; reads leave {mask, value} for the watcher
    task automatic wb(input logic w, input logic [5:0] a, input logic [15:0] d,
                      input logic [15:0] m);
        int n;
        n = 0;
        if (!w) exp_q.push_back({m, d & m});
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {16'h0000, d};
        sel_i <= 4'h3;
        @(posedge clk);
        while (ack_o !== 1'b1) begin
            n++;
            if (n > 20) begin
                bad_count++;
                $display("MISMATCH bus ack expected 1 seen timeout");
                close_out();
            end
            @(posedge clk);
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk);
    endtask

    // bounded wait for the interrupt line to reach a level
    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v) begin
            n++;
            if (n > 8) begin
                bad_count++;
                $display("MISMATCH irq expected %b seen timeout", v);
                close_out();
            end
            @(posedge clk);
        end
        chk("irq", {15'h0000, v}, {15'h0000, irq});
    endtask

    task automatic ack_irq();
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        @(posedge clk);
    endtask

    // watcher: read data compared at the ack edge, init pulses counted
    always @(posedge clk) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("MISMATCH read queue expected entry seen empty");
            end else begin
                mon_e = exp_q.pop_front();
                chk("read data", mon_e[15:0], dat_o[15:0] & mon_e[31:16]);
            end
        end
        if (drive_bus_init === 1'b1) init_cnt++;
    end

    initial begin
        rst = 1'b1;
        {cyc_i, stb_i, we_i, bus_init, irq_ack} = 5'h00;
        adr_i = 6'h00;
        sel_i = 4'h0;
        dat_i = 32'h0000_0000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b0, OFS_CS1, 16'h0080, 16'h0080);
        wb(1'b0, OFS_DS, 16'h0080, 16'h0080);
        lfsr = next_rand(next_rand(lfsr));
        rnd = lfsr[15:0];
        wb(1'b1, OFS_BA, rnd, 16'hffff);
        wb(1'b0, OFS_BA, rnd, 16'hffff);
        for (k0 = 0; k0 < 8; k0++) begin
            u_far.fire(8'h01 << k0, 1'b0, 5'h00, 1'b0, 16'h0000, 8'h00);
            wb(1'b0, OFS_CS2, 16'h0100 << k0, 16'hff00);
            wb(1'b0, OFS_CS1, 16'hc000, 16'hc000);
            wb(1'b1, OFS_CS1, 16'h4000, 16'hffff);
        end
        u_far.fire(8'h02, 1'b1, 5'h1f, 1'b0, 16'h0000, 8'h00);
        wb(1'b0, OFS_CS3, 16'hf800, 16'hf800);
        wb(1'b1, OFS_CS1, 16'h4000, 16'hffff);
        wb(1'b0, OFS_CS2, 16'h0000, 16'hff00);
        wb(1'b0, OFS_CS1, 16'h0000, 16'h6000);
        wb(1'b0, OFS_CS3, 16'h0000, 16'hf800);
        wb(1'b0, OFS_BA, rnd, 16'hffff);
        // controller clear with options and errors loaded
        wb(1'b1, OFS_BAE, rnd, 16'hffff);
        wb(1'b1, OFS_CS3, 16'h001f, 16'hffff);
        u_far.fire(8'hff, 1'b1, 5'h1f, 1'b0, 16'h0000, 8'h00);
        k0 = init_cnt;
        wb(1'b1, OFS_CS2, 16'h003b, 16'hffff);
        @(posedge clk);
        chk("init pulses", 16'h0001, 16'(init_cnt - k0));
        wb(1'b0, OFS_BA, 16'h0000, 16'hffff);
        wb(1'b0, OFS_BAE, 16'h0000, 16'h003f);
        wb(1'b0, OFS_CS2, 16'h0000, 16'hff1f);
        wb(1'b0, OFS_CS3, 16'h0000, 16'hf85f);
        wb(1'b0, OFS_CS1, 16'h0000, 16'he040);
        // host bus reset acts like controller clear
        wb(1'b1, OFS_BA, ~rnd, 16'hffff);
        wb(1'b1, OFS_DB, ~rnd, 16'hffff);
        k0 = init_cnt;
        bus_init <= 1'b1;
        @(posedge clk);
        bus_init <= 1'b0;
        repeat (2) @(posedge clk);
        chk("init pulses", 16'h0001, 16'(init_cnt - k0));
        wb(1'b0, OFS_BA, 16'h0000, 16'hffff);
        // interrupt by enable and ready written together, then again by rewrite
        wb(1'b1, OFS_CS1, 16'h00c0, 16'hffff);
        wait_irq(1'b1);
        ack_irq();
        chk("irq", 16'h0000, {15'h0000, irq});
        wb(1'b1, OFS_CS1, 16'h00c0, 16'hffff);
        wait_irq(1'b1);
        ack_irq();
        wb(1'b1, OFS_CS3, 16'h0040, 16'hffff);
        repeat (6) @(posedge clk);
        chk("irq", 16'h0000, {15'h0000, irq});
        // normal transfer ends at the gap
        wb(1'b1, OFS_CS1, 16'h0069, 16'hffff);
        chk("xfer_active", 16'h0001, {15'h0000, xfer_active});
        wb(1'b0, OFS_CS1, 16'h0000, 16'h0080);
        u_far.gap(3);
        wait_irq(1'b1);
        ack_irq();
        // controller error stops the transfer, ready waits for the gap
        wb(1'b1, OFS_CS1, 16'h0069, 16'hffff);
        u_far.fire(8'h80, 1'b0, 5'h00, 1'b0, 16'h0000, 8'h00);
        repeat (2) @(posedge clk);
        chk("xfer_active", 16'h0000, {15'h0000, xfer_active});
        wb(1'b0, OFS_CS1, 16'hc000, 16'hc080);
        chk("irq", 16'h0000, {15'h0000, irq});
        u_far.gap(2);
        wait_irq(1'b1);
        ack_irq();
        wb(1'b1, OFS_CS1, 16'h4040, 16'hffff);
        // attention while ready and enabled
        u_far.fire(8'h00, 1'b0, 5'h00, 1'b0, 16'h0000, 8'h01);
        wait_irq(1'b1);
        ack_irq();
        // drive error during a transfer
        wb(1'b1, OFS_CS1, 16'h0069, 16'hffff);
        lfsr = next_rand(lfsr);
        u_far.fire(8'h00, 1'b0, 5'h00, 1'b1, lfsr[15:0], 8'h00);
        wb(1'b0, OFS_CS1, 16'hc080, 16'hc080);
        wb(1'b0, OFS_DS, 16'hc080, 16'hc080);
        wb(1'b0, OFS_ER, lfsr[15:0], 16'hffff);
        wb(1'b1, OFS_CS1, 16'h4040, 16'hffff);
        wb(1'b0, OFS_DS, 16'h4000, 16'h4000);
        wb(1'b1, OFS_CS1, 16'h0069, 16'hffff);
        wb(1'b0, OFS_CS2, 16'h0200, 16'h0200);
        u_far.fire(8'h00, 1'b0, 5'h00, 1'b0, 16'h0000, 8'h02);
        wb(1'b1, OFS_CS1, 16'h0049, 16'hffff);
        wb(1'b0, OFS_DS, 16'h0000, 16'hc001);
        wb(1'b0, OFS_CS1, 16'h4000, 16'h4000);
        wb(1'b0, OFS_AS, 16'h0002, 16'h0002);
        ack_irq();
        // program abort during a transfer
        wb(1'b1, OFS_CS1, 16'h0029, 16'hffff);
        chk("xfer_active", 16'h0001, {15'h0000, xfer_active});
        wb(1'b1, OFS_CS2, 16'h0020, 16'hffff);
        chk("xfer_active", 16'h0000, {15'h0000, xfer_active});
        wb(1'b0, OFS_CS1, 16'h0080, 16'h0080);
        wb(1'b0, OFS_DS, 16'h0080, 16'hc080);
        // unmapped place reads zero and ignores writes
        wb(1'b1, 6'h3c, rnd, 16'hffff);
        wb(1'b0, 6'h3c, 16'h0000, 16'hffff);
        close_out();
    end
endmodule
`default_nettype wire

// ### verification/tcc_far_model.sv
// far side model: transfer engine and attached drives raising events
`timescale 1ns/1ps
`default_nettype none
module tcc_far_model
    import tcc_pkg::*;
(
    // clock
    input wire logic clk,
    // events toward the controller
    output logic gap_seen,
    output logic [7:0] ctl_err_set,
    output logic par_err_set,
    output logic [4:0] cs3_err_set,
    output logic drv_err_set,
    output logic [15:0] drv_err_bits,
    output logic [7:0] drv_attn_set,
    // status from the controller
    input wire logic xfer_active,
    input wire logic drive_bus_init
);
    logic tape_moving;
    // quiet event lines; unqualified error bits start at 16'h5a5a, not zero
    initial begin
        gap_seen = 1'b0;
        ctl_err_set = 8'h00;
        par_err_set = 1'b0;
        cs3_err_set = 5'h00;
        drv_err_set = 1'b0;
        drv_err_bits = 16'h5a5a;
        drv_attn_set = 8'h00;
        tape_moving = 1'b0;
    end
    // tape keeps moving after a controller error until the gap; init stops it at once
    always @(posedge clk) begin
        if (drive_bus_init === 1'b1) begin
            tape_moving <= 1'b0;
        end else if (gap_seen === 1'b1) begin
            tape_moving <= 1'b0;
        end else if (xfer_active === 1'b1) begin
            tape_moving <= 1'b1;
        end
    end
    // one-cycle event burst, launched just after a rising edge
    task automatic fire(input logic [7:0] ctl, input logic par, input logic [4:0] c3,
                        input logic derr, input logic [15:0] bits, input logic [7:0] attn);
        ctl_err_set <= ctl;
        par_err_set <= par;
        cs3_err_set <= c3;
        drv_err_set <= derr;
        drv_err_bits <= (bits == 16'h0000) ? ER_DEFAULT_BIT : bits;
        drv_attn_set <= attn;
        @(posedge clk);
        ctl_err_set <= 8'h00;
        par_err_set <= 1'b0;
        cs3_err_set <= 5'h00;
        drv_err_set <= 1'b0;
        drv_err_bits <= ~drv_err_bits;
        drv_attn_set <= 8'h00;
    endtask
    // a gap is only seen on moving tape, after a chosen delay
    task automatic gap(input int dly);
        repeat (dly) @(posedge clk);
        gap_seen <= tape_moving;
        @(posedge clk);
        gap_seen <= 1'b0;
    endtask
endmodule
`default_nettype wire
